/* File: core/timer_pkg.sv */
// Constants, register map and mode codes for the 16-bit PWM/capture timer
package timer_pkg;

  // Register byte offsets on the software port
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_CTL1 = 4'h1;
  localparam logic [3:0] ADDR_CNT_H = 4'h2;
  localparam logic [3:0] ADDR_CNT_L = 4'h3;
  localparam logic [3:0] ADDR_RLD_H = 4'h4;
  localparam logic [3:0] ADDR_RLD_L = 4'h5;
  localparam logic [3:0] ADDR_MAT_H = 4'h6;
  localparam logic [3:0] ADDR_MAT_L = 4'h7;

  // Field positions in timer_control_zero
  localparam int CTL0_CAP_BIT = 0;

  // Field positions in the second control register
  localparam int CTL1_EN_BIT = 7;
  localparam int CTL1_POL_BIT = 6;
  localparam int CTL1_MODE_HI = 5;
  localparam int CTL1_MODE_LO = 4;
  localparam int CTL1_PRE_HI = 3;
  localparam int CTL1_PRE_LO = 1;
  localparam int CTL1_PIN_BIT = 0;

  // Widths
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;
  localparam int PRE_W = 7;

  // Reset values and the restart count
  localparam logic [15:0] CNT_START = 16'h0001;
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam logic [15:0] RLD_RST = 16'hFFFF;
  localparam logic [15:0] MAT_RST = 16'h0000;
  localparam logic [2:0] PRE_SEL_RST = 3'h0;
  localparam logic [6:0] PRE_ONE = 7'h01;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_COMP_CNT = 2'b00,
    MODE_PWM_ONE = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_PWM_DUAL = 2'b11
  } mode_t;

endpackage : timer_pkg

/* File: core/pin_sync.sv */
// Three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pin_i,
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1_reg, s2_reg, s3_reg;
  logic lvl_reg, lvl_next;
  logic rise_reg, rise_next;
  logic fall_reg, fall_next;

  // Accept a change only when stages two and three agree
  always_comb begin
    lvl_next = lvl_reg;
    rise_next = 1'b0;
    fall_next = 1'b0;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
      rise_next = s3_reg & ~lvl_reg;
      fall_next = ~s3_reg & lvl_reg;
    end
  end

  // Shift chain and filtered state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign level = lvl_reg;
  assign rise = rise_reg;
  assign fall = fall_reg;

endmodule : pin_sync

`default_nettype wire

/* File: core/timer_pwm_capture_modes.sv */
// 16-bit timer with comparator counting, PWM and input capture modes
//
// Functional notes
// - Comparator mode counts comparator edges chosen by the polarity bit.
// - Comparator mode restarts at 0001H after each reload; start count only first.
// - Single PWM counts prescaled system clock, toggles output at match.
// - Single PWM at reload raises interrupt, restarts at 0001H, keeps counting.
// - Polarity one: output starts high, low at match, high on reload.
// - Polarity zero: high fraction is (reload minus match) over reload.
// - Polarity one: high fraction is match over reload.
// - PWM period equals reload times prescale over system clock.
// - A start other than 0001H makes the first period start to reload.
// - Dual PWM turns the timer input pin into the complementary output.
// - Capture mode copies the running count into match on input edge.
// - Polarity bit picks rising or falling input edge for capture.
// - Capture raises interrupt, keeps counting, sets the capture flag.
// - Capture-mode reload raises interrupt, keeps counting, clears the flag.
`timescale 1ns/1ps
`default_nettype none

module timer_pwm_capture_modes (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tin_i,
  output logic tin_o,
  output logic tin_oe_n,
  output logic tout_o,
  output logic tout_oe_n,
  input wire logic comp_i,
  output logic timer_irq
);

  // Selected edge: polarity zero takes rising, one takes falling
  function automatic logic pick_edge(input logic pol, input logic rise,
                                     input logic fall);
    pick_edge = pol ? fall : rise;
  endfunction : pick_edge

  // Terminal count of the prescaler for a divide by two to the power sel
  function automatic logic [6:0] pre_limit(input logic [2:0] sel);
    pre_limit = (timer_pkg::PRE_ONE << sel) - timer_pkg::PRE_ONE;
  endfunction : pre_limit

  // Synchronised pin edges
  logic tin_rise, tin_fall;
  logic comp_rise, comp_fall;

  // Raw pins and edge pulses, one lane per synchronised input
  localparam int PIN_TIN = 0;
  localparam int PIN_COMP = 1;
  localparam int PIN_N = 2;
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  // Configuration
  logic en_reg, en_next;
  logic pol_reg, pol_next;
  timer_pkg::mode_t mode_reg, mode_next;
  logic [2:0] pre_sel_reg, pre_sel_next;
  logic pin_en_reg, pin_en_next;

  // Counter, reload, match and status
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] rld_reg, rld_next;
  logic [15:0] mat_reg, mat_next;
  logic cap_flag_reg, cap_flag_next;
  logic out_reg, out_next;
  logic irq_reg, irq_next;

  // Pin drivers
  logic tout_oe_n_reg, tout_oe_n_next;
  logic tin_o_reg, tin_o_next;
  logic tin_oe_n_reg, tin_oe_n_next;

  // Prescaler
  logic [6:0] pre_reg, pre_next;
  logic pre_tick;

  // Read port
  logic [7:0] rdata_reg, rdata_next;

  // Decoded control
  logic is_pwm;
  logic step;
  logic cap_edge;
  logic [15:0] cnt_inc;
  logic [7:0] ctl1_wr;

  // Input lanes: comparator output above, timer input pin below
  assign pin_raw = {comp_i, tin_i};

  // One three-stage synchroniser per input lane
  for (genvar gi = 0; gi < PIN_N; gi++) begin : g_sync
    pin_sync u_pin_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pin_i(pin_raw[gi]),
      .level(),
      .rise(pin_rise[gi]),
      .fall(pin_fall[gi])
    );
  end

  // Edge pulses by name
  assign tin_rise = pin_rise[PIN_TIN];
  assign tin_fall = pin_fall[PIN_TIN];
  assign comp_rise = pin_rise[PIN_COMP];
  assign comp_fall = pin_fall[PIN_COMP];

  // Prescaler runs only while enabled and restarts when stopped
  always_comb begin
    pre_tick = en_reg && (pre_reg == pre_limit(pre_sel_reg));
    pre_next = pre_reg;
    if (!en_reg) begin
      pre_next = '0;
    end else if (pre_tick) begin
      pre_next = '0;
    end else begin
      pre_next = pre_reg + timer_pkg::PRE_ONE;
    end
  end

  // Prescaler state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // Count source and capture strobe
  always_comb begin
    is_pwm = (mode_reg == timer_pkg::MODE_PWM_ONE) ||
             (mode_reg == timer_pkg::MODE_PWM_DUAL);
    if (mode_reg == timer_pkg::MODE_COMP_CNT) begin
      step = en_reg && pick_edge(pol_reg, comp_rise, comp_fall);
    end else begin
      step = pre_tick;
    end
    cap_edge = en_reg && (mode_reg == timer_pkg::MODE_CAPTURE) &&
               pick_edge(pol_reg, tin_rise, tin_fall);
    cnt_inc = cnt_reg + timer_pkg::CNT_START;
    ctl1_wr = reg_wdata;
  end

  // Register writes, counting, output level and capture
  always_comb begin
    en_next = en_reg;
    pol_next = pol_reg;
    mode_next = mode_reg;
    pre_sel_next = pre_sel_reg;
    pin_en_next = pin_en_reg;
    cnt_next = cnt_reg;
    rld_next = rld_reg;
    mat_next = mat_reg;
    cap_flag_next = cap_flag_reg;
    out_next = out_reg;
    irq_next = 1'b0;

    // Count step: reload restarts at the fixed start value
    if (step) begin
      if (cnt_reg == rld_reg) begin
        cnt_next = timer_pkg::CNT_START;
        irq_next = 1'b1;
        if (is_pwm) begin
          out_next = pol_reg;
        end else begin
          out_next = ~out_reg;
        end
        if (mode_reg == timer_pkg::MODE_CAPTURE) begin
          cap_flag_next = 1'b0;
        end
      end else begin
        cnt_next = cnt_inc;
        if (is_pwm && (cnt_reg == mat_reg)) begin
          out_next = ~out_reg;
        end
      end
    end

    // Software writes to the byte registers
    if (reg_wr) begin
      unique case (reg_addr)
        timer_pkg::ADDR_CTL1: begin
          en_next = ctl1_wr[timer_pkg::CTL1_EN_BIT];
          pol_next = ctl1_wr[timer_pkg::CTL1_POL_BIT];
          mode_next = timer_pkg::mode_t'(
            ctl1_wr[timer_pkg::CTL1_MODE_HI:timer_pkg::CTL1_MODE_LO]);
          pre_sel_next = ctl1_wr[timer_pkg::CTL1_PRE_HI:timer_pkg::CTL1_PRE_LO];
          pin_en_next = ctl1_wr[timer_pkg::CTL1_PIN_BIT];
          if (ctl1_wr[timer_pkg::CTL1_EN_BIT] && !en_reg) begin
            out_next = ctl1_wr[timer_pkg::CTL1_POL_BIT];
          end
        end
        timer_pkg::ADDR_CNT_H: begin
          cnt_next[timer_pkg::CNT_W-1:timer_pkg::DATA_W] = reg_wdata;
        end
        timer_pkg::ADDR_CNT_L: begin
          cnt_next[timer_pkg::DATA_W-1:0] = reg_wdata;
        end
        timer_pkg::ADDR_RLD_H: begin
          rld_next[timer_pkg::CNT_W-1:timer_pkg::DATA_W] = reg_wdata;
        end
        timer_pkg::ADDR_RLD_L: begin
          rld_next[timer_pkg::DATA_W-1:0] = reg_wdata;
        end
        timer_pkg::ADDR_MAT_H: begin
          mat_next[timer_pkg::CNT_W-1:timer_pkg::DATA_W] = reg_wdata;
        end
        timer_pkg::ADDR_MAT_L: begin
          mat_next[timer_pkg::DATA_W-1:0] = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // Capture overrides a same-cycle reload clear and a match write
    if (cap_edge) begin
      mat_next = cnt_reg;
      cap_flag_next = 1'b1;
      irq_next = 1'b1;
    end
  end

  // Configuration, counter and status state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= 1'b0;
      pol_reg <= 1'b0;
      mode_reg <= timer_pkg::MODE_COMP_CNT;
      pre_sel_reg <= timer_pkg::PRE_SEL_RST;
      pin_en_reg <= 1'b0;
      cnt_reg <= timer_pkg::CNT_RST;
      rld_reg <= timer_pkg::RLD_RST;
      mat_reg <= timer_pkg::MAT_RST;
      cap_flag_reg <= 1'b0;
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      pol_reg <= pol_next;
      mode_reg <= mode_next;
      pre_sel_reg <= pre_sel_next;
      pin_en_reg <= pin_en_next;
      cnt_reg <= cnt_next;
      rld_reg <= rld_next;
      mat_reg <= mat_next;
      cap_flag_reg <= cap_flag_next;
      out_reg <= out_next;
      irq_reg <= irq_next;
    end
  end

  // Pin drive: enables are low while driving
  always_comb begin
    tout_oe_n_next = ~pin_en_next;
    tin_oe_n_next = ~(mode_next == timer_pkg::MODE_PWM_DUAL);
    tin_o_next = ~out_next;
  end

  // Pin driver state, released during reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tout_oe_n_reg <= 1'b1;
      tin_oe_n_reg <= 1'b1;
      tin_o_reg <= 1'b1;
    end else begin
      tout_oe_n_reg <= tout_oe_n_next;
      tin_oe_n_reg <= tin_oe_n_next;
      tin_o_reg <= tin_o_next;
    end
  end

  // Read mux: data stand one cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        timer_pkg::ADDR_CTL0: begin
          rdata_next[timer_pkg::CTL0_CAP_BIT] = cap_flag_reg;
        end
        timer_pkg::ADDR_CTL1: begin
          rdata_next[timer_pkg::CTL1_EN_BIT] = en_reg;
          rdata_next[timer_pkg::CTL1_POL_BIT] = pol_reg;
          rdata_next[timer_pkg::CTL1_MODE_HI:timer_pkg::CTL1_MODE_LO] = mode_reg;
          rdata_next[timer_pkg::CTL1_PRE_HI:timer_pkg::CTL1_PRE_LO] = pre_sel_reg;
          rdata_next[timer_pkg::CTL1_PIN_BIT] = pin_en_reg;
        end
        timer_pkg::ADDR_CNT_H: begin
          rdata_next = cnt_reg[timer_pkg::CNT_W-1:timer_pkg::DATA_W];
        end
        timer_pkg::ADDR_CNT_L: begin
          rdata_next = cnt_reg[timer_pkg::DATA_W-1:0];
        end
        timer_pkg::ADDR_RLD_H: begin
          rdata_next = rld_reg[timer_pkg::CNT_W-1:timer_pkg::DATA_W];
        end
        timer_pkg::ADDR_RLD_L: begin
          rdata_next = rld_reg[timer_pkg::DATA_W-1:0];
        end
        timer_pkg::ADDR_MAT_H: begin
          rdata_next = mat_reg[timer_pkg::CNT_W-1:timer_pkg::DATA_W];
        end
        timer_pkg::ADDR_MAT_L: begin
          rdata_next = mat_reg[timer_pkg::DATA_W-1:0];
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign tout_o = out_reg;
  assign tout_oe_n = tout_oe_n_reg;
  assign tin_o = tin_o_reg;
  assign tin_oe_n = tin_oe_n_reg;
  assign timer_irq = irq_reg;

endmodule : timer_pwm_capture_modes

`default_nettype wire

/* File: verification/timer_pwm_capture_modes_chk.sv */
// Port assertions for the PWM/capture timer
`timescale 1ns/1ps
`default_nettype none

module timer_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tin_o,
  input wire logic tin_oe_n,
  input wire logic tout_o,
  input wire logic tout_oe_n,
  input wire logic timer_irq
);
  logic en_reg;
  logic ctl_wr;

  // Control register write seen on the port
  assign ctl_wr = reg_wr && (reg_addr == timer_pkg::ADDR_CTL1);

  // Enable bit as last written by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= 1'b0;
    end else if (ctl_wr) begin
      en_reg <= reg_wdata[timer_pkg::CTL1_EN_BIT];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Timer stopped with no control write pending
  sequence s_off2;
    (!en_reg && !ctl_wr)[*2];
  endsequence

  property p_rd_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");

  property p_pair;
    tin_o == !tout_o;
  endproperty
  a_pair: assert property (p_pair) else $error("complement output wrong");

  property p_pin_en;
    ctl_wr |=> tout_oe_n == !$past(reg_wdata[0]);
  endproperty
  a_pin_en: assert property (p_pin_en) else $error("output pin enable wrong");

  property p_dual_pin;
    ctl_wr |=> tin_oe_n == ($past(reg_wdata[5:4]) != 2'b11);
  endproperty
  a_dual_pin: assert property (p_dual_pin) else $error("input pin enable wrong");

  property p_start_pol;
    ctl_wr && reg_wdata[7] && !en_reg |=> tout_o == $past(reg_wdata[6]);
  endproperty
  a_start_pol: assert property (p_start_pol) else $error("start level wrong");

  property p_frozen;
    s_off2 |=> $stable(tout_o);
  endproperty
  a_frozen: assert property (p_frozen) else $error("output moved while off");

  property p_oe_hold;
    !ctl_wr |=> $stable(tout_oe_n) && $stable(tin_oe_n);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");

  property p_no_irq_off;
    (!en_reg)[*3] |-> !timer_irq;
  endproperty
  a_no_irq_off: assert property (p_no_irq_off) else $error("irq while off");

endmodule : timer_chk

bind timer_pwm_capture_modes timer_chk u_timer_chk (
  .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .tin_o, .tin_oe_n, .tout_o, .tout_oe_n, .timer_irq
);

`default_nettype wire

/* File: verification/pin_model.sv */
// External timer input pin and comparator output model
`timescale 1ns/1ps
`default_nettype none

module pin_model (
  input wire logic comp_cmd,
  input wire logic tin_cmd,
  output logic comp_o,
  output logic tin_lvl
);
  // Levels settle a few ns after each command, away from the clock edge
  assign #3 comp_o = comp_cmd;
  assign #3 tin_lvl = tin_cmd;
endmodule : pin_model

`default_nettype wire

/* File: verification/timer_pwm_capture_modes_bench.sv */
// Self-checking bench for the PWM/capture timer
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module timer_pwm_capture_modes_bench;
  logic clk, arst_n, reg_wr, reg_rd, tin_i, tin_o, tin_oe_n, tout_o, tout_oe_n;
  logic comp_i, timer_irq, comp_cmd, tin_cmd, tin_pm;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] m;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_irq = 0;
  int k, hi, t0;

  // Shared input pin: design drives it in dual PWM, else the model does
  assign tin_i = tin_oe_n ? tin_pm : tin_o;

  timer_pwm_capture_modes u_timer_pwm_capture_modes (.clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .tin_i, .tin_o, .tin_oe_n, .tout_o, .tout_oe_n, .comp_i,
    .timer_irq);
  pin_model u_pin_model (.comp_cmd, .tin_cmd, .comp_o(comp_i), .tin_lvl(tin_pm));

  // Clock and interrupt pulse count
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (timer_irq === 1'b1) n_irq <= n_irq + 1;

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 4'h1, v[7:0]);
  endtask : wr16

  task chk8(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK("reg byte", e, v)
  endtask : chk8

  task chk16(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v[15:8]);
    rd(a + 4'h1, v[7:0]);
    `CHK("reg pair", e, v)
  endtask : chk16

  // Disable, load count, reload and match, then enable last
  task setup(input timer_pkg::mode_t md, input logic pol, input logic [2:0] pre,
             input logic pin, input logic [15:0] cnt, input logic [15:0] rld,
             input logic [15:0] mat);
    wr(timer_pkg::ADDR_CTL1, 8'h00);
    wr16(timer_pkg::ADDR_CNT_H, cnt);
    wr16(timer_pkg::ADDR_RLD_H, rld);
    wr16(timer_pkg::ADDR_MAT_H, mat);
    wr(timer_pkg::ADDR_CTL1, {1'b1, pol, md, pre, pin});
  endtask : setup

  task stop_test;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // Hang guard
  initial begin
    #500us;
    n_mismatch++;
    stop_test();
  end

  // Main sequence
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    comp_cmd = 1'b0;
    tin_cmd = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    chk8(timer_pkg::ADDR_CTL0, 8'h00);
    chk8(timer_pkg::ADDR_CTL1, 8'h00);
    chk16(timer_pkg::ADDR_CNT_H, timer_pkg::CNT_RST);
    chk16(timer_pkg::ADDR_RLD_H, timer_pkg::RLD_RST);
    chk16(timer_pkg::ADDR_MAT_H, timer_pkg::MAT_RST);
    chk8(4'h8, 8'h00);
    // Comparator: five toggles give three rises and two falls
    for (int p = 0; p < 2; p++) begin
      setup(timer_pkg::MODE_COMP_CNT, p[0], 3'h0, 1'b0, 16'h0002, 16'h0003, 16'h0000);
      k = n_irq;
      repeat (5) begin
        repeat (10) @(posedge clk);
        comp_cmd <= ~comp_cmd;
      end
      repeat (10) @(posedge clk);
      wr(timer_pkg::ADDR_CTL1, 8'h00);
      chk16(timer_pkg::ADDR_CNT_H, p ? 16'h0001 : 16'h0002);
      `CHK("comparator irq", 1, n_irq - k)
      comp_cmd <= 1'b0;
    end
    // Single PWM, prescale 2, reload 8, match 3: two periods sampled
    for (int p = 0; p < 2; p++) begin
      setup(timer_pkg::MODE_PWM_ONE, p[0], 3'h1, p[0], 16'h0001, 16'h0008, 16'h0003);
      repeat (40) @(posedge clk);
      #1;
      k = n_irq;
      hi = 0;
      repeat (32) begin
        @(posedge clk);
        #1;
        hi += (tout_o === 1'b1);
      end
      `CHK("high cycles", 2 * 2 * (p ? 3 : 8 - 3), hi)
      `CHK("pwm irq", 2, n_irq - k)
      `CHK("tout_oe_n", !p[0], tout_oe_n)
    end
    // Start count 6 shortens the first period
    setup(timer_pkg::MODE_PWM_ONE, 1'b1, 3'h0, 1'b1, 16'h0006, 16'h0008, 16'h0003);
    k = n_irq;
    t0 = 0;
    while (n_irq == k && t0 < 20) begin
      @(posedge clk);
      #1;
      t0++;
    end
    `CHK("short first period", 1'b1, t0 < 7)
    // Dual PWM takes over the input pin
    setup(timer_pkg::MODE_PWM_DUAL, 1'b1, 3'h0, 1'b1, 16'h0001, 16'h0008, 16'h0003);
    repeat (3) @(posedge clk);
    #1;
    `CHK("tin_oe_n", 1'b0, tin_oe_n)
    // Capture on rising then falling input, reload clears the flag
    for (int p = 0; p < 2; p++) begin
      setup(timer_pkg::MODE_CAPTURE, p[0], 3'h0, 1'b0, 16'h0001, 16'h0040, 16'h0000);
      k = n_irq;
      repeat (10) @(posedge clk);
      tin_cmd <= ~tin_cmd;
      repeat (10) @(posedge clk);
      rd(timer_pkg::ADDR_MAT_H, m[15:8]);
      rd(timer_pkg::ADDR_MAT_L, m[7:0]);
      `CHK("capture value", 1'b1, m >= 16'h000B && m <= 16'h0014)
      `CHK("capture irq", 1, n_irq - k)
      chk8(timer_pkg::ADDR_CTL0, 8'h01);
      repeat (50) @(posedge clk);
      chk8(timer_pkg::ADDR_CTL0, 8'h00);
      `CHK("reload irq", 2, n_irq - k)
    end
    wr(timer_pkg::ADDR_CTL1, 8'h00);
    stop_test();
  end
endmodule : timer_pwm_capture_modes_bench

`default_nettype wire
